/* File: hw/fram_wel_pkg.sv */
package fram_wel_pkg;

    // ************************************************************
    // Command opcodes
    // ************************************************************
    localparam logic [7:0] OP_SET_WE    = 8'h06; // Set write enable
    localparam logic [7:0] OP_CLR_WE    = 8'h04; // Clear write enable
    localparam logic [7:0] OP_STAT_WR   = 8'h01; // Status write
    localparam logic [7:0] OP_WR_LO     = 8'h02; // Array write, A = 0
    localparam logic [7:0] OP_RD_LO     = 8'h03; // Array read, A = 0
    localparam logic [7:0] OP_WR_HI     = 8'h0A; // Array write, A = 1
    localparam logic [7:0] OP_RD_HI     = 8'h0B; // Array read, A = 1
    localparam logic [7:0] OP_ADDR_MASK = 8'hF7; // Hides opcode address bit
    localparam int         OP_ADDR_BIT  = 3;     // Opcode bit holding A

    // ************************************************************
    // Status register layout
    // ************************************************************
    localparam int         ST_WEL_BIT   = 1;     // Write enable latch
    localparam int         ST_BP_LO_BIT = 2;     // Block protect low
    localparam int         ST_BP_HI_BIT = 3;     // Block protect high
    localparam logic [7:0] STATUS_RESET = 8'h00; // Value after reset

    // ************************************************************
    // Array geometry and crossing
    // ************************************************************
    localparam int         ADDR_W       = 9;     // 512 byte array
    localparam int         SYNC_STAGES  = 2;     // Synchroniser depth

endpackage : fram_wel_pkg

/* File: hw/level_sync.sv */
`timescale 1ns/1ps

// ************************************************************
// Two flip-flop level synchroniser
// ************************************************************
module level_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Levels from another domain
    input  wire logic [WIDTH-1:0] i_async,
    // Levels safe to use
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q; // First stage, read only by second
    logic [WIDTH-1:0] sync_q; // Second stage

    // Both stages take the reset value together
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : level_sync

/* File: hw/spi_byte_rx.sv */
`timescale 1ns/1ps

// ************************************************************
// Serial clock side: bytes in, MSB first
// ************************************************************
module spi_byte_rx (
    // Serial clock and system reset
    input  wire logic       i_sck,
    input  wire logic       i_rst_n,
    // Frame and data pins
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    // Byte handed to the system clock
    output logic [7:0]      o_byte,
    output logic            o_toggle
);

    logic [2:0] bit_cnt_q; // Bits taken in this byte
    logic [6:0] shift_q;   // Bits gathered so far
    logic [7:0] byte_q;    // Last whole byte, stable for 8 edges
    logic       toggle_q;  // Flips once per whole byte

    // Bit count, cleared by the frame itself since the clock may stop
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_q <= 3'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Shift on rising edge, first bit is the MSB
    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_q  <= 7'h00;
            byte_q   <= 8'h00;
            toggle_q <= 1'b0;
        end else if (!i_cs_n) begin
            shift_q <= {shift_q[5:0], i_mosi};
            // Eighth bit completes the byte
            if (bit_cnt_q == 3'h7) begin
                byte_q   <= {shift_q, i_mosi};
                toggle_q <= ~toggle_q;
            end
        end
    end

    assign o_byte   = byte_q;
    assign o_toggle = toggle_q;

endmodule : spi_byte_rx

/* File: hw/fram_wel_ctrl.sv */
`timescale 1ns/1ps

// Behaviour
// - Set-write-enable opcode sets the latch
// - Status bit 1 shows the latch
// - Status write data never sets the latch bit
// - Finished lower-half write or status write clears latch
// - Upper-half array write leaves latch set
// - Array opcodes 0000A010 write, 0000A011 read
// - Opcodes 02/03 lower, 0A/0B upper half
// - Nine address bits, top from opcode
// - Status bits 0, 4-7 read zero
// - Latch cleared after reset
// - Bits 2, 3 hold protect, reset zero
// - Clear-write-enable opcode clears the latch
module fram_wel_ctrl (
    // System clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Serial link pins
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    // Status register contents
    output logic [7:0]      o_status,
    // Array access port
    output logic            o_mem_wr,
    output logic            o_mem_rd,
    output logic [8:0]      o_mem_addr,
    output logic [7:0]      o_mem_wdata
);

    // ************************************************************
    // Types and declarations
    // ************************************************************
    typedef enum logic [2:0] {
        ST_OPCODE,  // Waiting for the opcode byte
        ST_ADDR,    // Waiting for the low address byte
        ST_DATA,    // Array data bytes
        ST_STATUS,  // Status data byte
        ST_IGNORE   // Rest of frame discarded
    } cmd_state_e;

    cmd_state_e cmd_state_q;     // Command phase
    logic [7:0] rx_byte;         // Byte from serial side
    logic       rx_toggle;       // Toggle from serial side
    logic       tog_s;           // Synchronised toggle
    logic       tog_q;           // Previous synchronised toggle
    logic       cs_s;            // Synchronised chip select
    logic       cs_q;            // Delayed chip select
    logic       byte_evt;        // One whole byte arrived
    logic       cs_rise;         // Frame ended
    logic       wel_q;           // Write enable latch
    logic [1:0] bp_q;            // Block protect pair
    logic       is_wr;           // Opcode is array write
    logic       is_rd;           // Opcode is array read
    logic       write_mode_q;    // Array command writes
    logic       upper_q;         // Opcode address bit
    logic [8:0] addr_q;          // Running array address
    logic       wr_done_q;       // Array byte written this frame
    logic       sr_done_q;       // Status written this frame
    logic       mem_wr_q;        // Write strobe
    logic       mem_rd_q;        // Read strobe
    logic [7:0] wdata_q;         // Write data
    logic [8:0] maddr_q;         // Strobe address
    logic       after_rst_q;     // First cycle after reset

    // ************************************************************
    // Serial side and crossings
    // ************************************************************
    // Byte assembly on the link clock
    spi_byte_rx u_rx (
        .i_sck    (i_sck),
        .i_rst_n  (i_rst_n),
        .i_cs_n   (i_cs_n),
        .i_mosi   (i_mosi),
        .o_byte   (rx_byte),
        .o_toggle (rx_toggle)
    );

    // Byte toggle into system clock
    level_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tog_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (rx_toggle),
        .o_sync  (tog_s)
    );

    // Chip select into system clock, idle high
    level_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_cs_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_cs_n),
        .o_sync  (cs_s)
    );

    // Edge memories; chip select lags so the last byte lands first
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            tog_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            tog_q <= tog_s;
            cs_q  <= cs_s;
        end
    end

    assign byte_evt = tog_s ^ tog_q;
    assign cs_rise  = cs_s & ~cs_q;

    // Opcode decode with address bit masked off
    assign is_wr = (rx_byte & fram_wel_pkg::OP_ADDR_MASK)
                   == fram_wel_pkg::OP_WR_LO;
    assign is_rd = (rx_byte & fram_wel_pkg::OP_ADDR_MASK)
                   == fram_wel_pkg::OP_RD_LO;

    // ************************************************************
    // Command sequencer
    // ************************************************************
    // Phase advance per byte, back to opcode at frame end
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cmd_state_q <= ST_OPCODE;
        end else if (cs_rise) begin
            cmd_state_q <= ST_OPCODE;
        end else if (byte_evt) begin
            case (cmd_state_q)
                ST_OPCODE: begin
                    if (is_wr || is_rd) begin
                        cmd_state_q <= ST_ADDR;
                    end else if (rx_byte == fram_wel_pkg::OP_STAT_WR) begin
                        cmd_state_q <= ST_STATUS;
                    end else begin
                        cmd_state_q <= ST_IGNORE;
                    end
                end
                ST_ADDR:   cmd_state_q <= ST_DATA;
                ST_STATUS: cmd_state_q <= ST_IGNORE;
                default:   cmd_state_q <= cmd_state_q;
            endcase
        end
    end

    // Opcode fields kept for the frame
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            write_mode_q <= 1'b0;
            upper_q      <= 1'b0;
        end else if (byte_evt && cmd_state_q == ST_OPCODE) begin
            write_mode_q <= is_wr;
            // Ninth address bit from the opcode
            upper_q      <= rx_byte[fram_wel_pkg::OP_ADDR_BIT];
        end
    end

    // Running address, wraps within the array
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            addr_q <= 9'h000;
        end else if (byte_evt && cmd_state_q == ST_ADDR) begin
            addr_q <= {upper_q, rx_byte};
        end else if (byte_evt && cmd_state_q == ST_DATA) begin
            addr_q <= addr_q + 9'h001;
        end
    end

    // ************************************************************
    // Array strobes
    // ************************************************************
    // Write only while enabled; read requested ahead of each byte
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            wdata_q  <= 8'h00;
            maddr_q  <= 9'h000;
        end else begin
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            if (byte_evt && cmd_state_q == ST_ADDR && !write_mode_q) begin
                // First read address
                mem_rd_q <= 1'b1;
                maddr_q  <= {upper_q, rx_byte};
            end else if (byte_evt && cmd_state_q == ST_DATA) begin
                if (write_mode_q && wel_q) begin
                    mem_wr_q <= 1'b1;
                    wdata_q  <= rx_byte;
                    maddr_q  <= addr_q;
                end else if (!write_mode_q) begin
                    mem_rd_q <= 1'b1;
                    maddr_q  <= addr_q + 9'h001;
                end
            end
        end
    end

    // Completed writes this frame
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || cs_rise) begin
            wr_done_q <= 1'b0;
            sr_done_q <= 1'b0;
        end else if (byte_evt && wel_q) begin
            if (cmd_state_q == ST_DATA && write_mode_q) begin
                wr_done_q <= 1'b1;
            end
            if (cmd_state_q == ST_STATUS) begin
                sr_done_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Status register
    // ************************************************************
    // Write enable latch
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wel_q <= fram_wel_pkg::STATUS_RESET[fram_wel_pkg::ST_WEL_BIT];
        end else if (cs_rise) begin
            // Upper-half writes fail to clear
            if (sr_done_q || (wr_done_q && !upper_q)) begin
                wel_q <= 1'b0;
            end
        end else if (byte_evt && cmd_state_q == ST_OPCODE) begin
            if (rx_byte == fram_wel_pkg::OP_SET_WE) begin
                wel_q <= 1'b1;
            end else if (rx_byte == fram_wel_pkg::OP_CLR_WE) begin
                wel_q <= 1'b0;
            end
        end
    end

    // Protect pair; latch bit of the data byte is ignored
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            bp_q <= {fram_wel_pkg::STATUS_RESET[fram_wel_pkg::ST_BP_HI_BIT],
                     fram_wel_pkg::STATUS_RESET[fram_wel_pkg::ST_BP_LO_BIT]};
        end else if (byte_evt && cmd_state_q == ST_STATUS && wel_q) begin
            bp_q <= {rx_byte[fram_wel_pkg::ST_BP_HI_BIT],
                     rx_byte[fram_wel_pkg::ST_BP_LO_BIT]};
        end
    end

    // Status image, unused bits zero
    always_comb begin
        o_status = 8'h00;
        o_status[fram_wel_pkg::ST_WEL_BIT]   = wel_q;
        o_status[fram_wel_pkg::ST_BP_LO_BIT] = bp_q[0];
        o_status[fram_wel_pkg::ST_BP_HI_BIT] = bp_q[1];
    end

    assign o_mem_wr    = mem_wr_q;
    assign o_mem_rd    = mem_rd_q;
    assign o_mem_addr  = maddr_q;
    assign o_mem_wdata = wdata_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Marks the first cycle after reset
    always_ff @(posedge i_clock) begin
        after_rst_q <= !i_rst_n;
    end

    property p_set_we;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && !cs_rise && cmd_state_q == ST_OPCODE
            && rx_byte == fram_wel_pkg::OP_SET_WE |=> o_status[1];
    endproperty
    a_set_we: assert property (p_set_we)
        else $error("latch not set by enable opcode");

    property p_wel_cause;
        @(posedge i_clock) disable iff (!i_rst_n)
        $rose(o_status[1]) |-> $past(byte_evt)
            && $past(rx_byte) == fram_wel_pkg::OP_SET_WE;
    endproperty
    a_wel_cause: assert property (p_wel_cause)
        else $error("status bit 1 rose without enable opcode");

    property p_sr_keeps_wel;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && cmd_state_q == ST_STATUS && wel_q && !cs_rise
            |=> o_status[1] && o_status[3:2] == $past(rx_byte[3:2]);
    endproperty
    a_sr_keeps_wel: assert property (p_sr_keeps_wel)
        else $error("status write changed latch or missed protect");

    property p_end_clears;
        @(posedge i_clock) disable iff (!i_rst_n)
        cs_rise && (sr_done_q || (wr_done_q && !upper_q)) |=> !o_status[1];
    endproperty
    a_end_clears: assert property (p_end_clears)
        else $error("latch survived a finished write");

    property p_upper_keeps;
        @(posedge i_clock) disable iff (!i_rst_n)
        cs_rise && wr_done_q && upper_q && !sr_done_q |=> o_status[1];
    endproperty
    a_upper_keeps: assert property (p_upper_keeps)
        else $error("upper half write cleared latch");

    property p_hi_decode;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && !cs_rise && cmd_state_q == ST_OPCODE
            && rx_byte == fram_wel_pkg::OP_WR_HI
            |=> cmd_state_q == ST_ADDR && upper_q && write_mode_q;
    endproperty
    a_hi_decode: assert property (p_hi_decode)
        else $error("upper write opcode misdecoded");

    property p_rd_decode;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && !cs_rise && cmd_state_q == ST_OPCODE
            && rx_byte == fram_wel_pkg::OP_RD_LO
            |=> cmd_state_q == ST_ADDR && !upper_q && !write_mode_q;
    endproperty
    a_rd_decode: assert property (p_rd_decode)
        else $error("lower read opcode misdecoded");

    // Start address joins the opcode bit to the address byte
    property p_addr_top;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && cmd_state_q == ST_ADDR
            |=> addr_q == {upper_q, $past(rx_byte)};
    endproperty
    a_addr_top: assert property (p_addr_top)
        else $error("start address not joined to opcode bit");

    // Write strobe only from a write command with the latch set
    property p_wr_needs_wel;
        @(posedge i_clock) disable iff (!i_rst_n)
        o_mem_wr |-> $past(wel_q) && $past(write_mode_q);
    endproperty
    a_wr_needs_wel: assert property (p_wr_needs_wel)
        else $error("write strobe while latch off");

    property p_zero_bits;
        @(posedge i_clock) disable iff (!i_rst_n)
        o_status[0] == 1'b0 && o_status[7:4] == 4'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("unused status bits not zero");

    property p_reset_val;
        @(posedge i_clock) disable iff (!i_rst_n)
        after_rst_q |-> o_status == 8'h00;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("status not zero after reset");

    property p_clr_we;
        @(posedge i_clock) disable iff (!i_rst_n)
        byte_evt && !cs_rise && cmd_state_q == ST_OPCODE
            && rx_byte == fram_wel_pkg::OP_CLR_WE |=> !o_status[1] [*2];
    endproperty
    a_clr_we: assert property (p_clr_we)
        else $error("latch not cleared by clear opcode");

    c_wr_lo: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        cs_rise && wr_done_q && !upper_q);
    c_wr_hi: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        cs_rise && wr_done_q && upper_q);
    c_sr_wr: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        cs_rise && sr_done_q);
    c_rd:    cover property (@(posedge i_clock) disable iff (!i_rst_n)
        o_mem_rd ##[1:60] o_mem_rd);

endmodule : fram_wel_ctrl

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ps

// ************************************************************
// Serial host: frames on an 80 ns link clock
// ************************************************************
module spi_host_model (
    // Link pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi
);
    // Idle: clock parked low, frame closed
    // Select rises after time zero so the bit count clear is seen
    initial begin
        o_sck  = 1'b0;
        o_mosi = 1'b0;
        #1;
        o_cs_n = 1'b1;
    end

    // One frame of n bytes from the top of b, MSB first
    task automatic send_frame(input logic [31:0] b, input int n);
        int i;
        int k;
        #13;
        o_cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            for (k = 7; k >= 0; k--) begin
                o_mosi = b[8*(3-i)+k];
                #40 o_sck = 1'b1;
                #40 o_sck = 1'b0;
            end
        end
        #150 o_cs_n = 1'b1;
        // Line no longer meaningful: show no stale level
        o_mosi = ~o_mosi;
        #200;
    endtask : send_frame
endmodule : spi_host_model

/* File: verification/test_spi_fram_write_enable_ctrl.sv */
`timescale 1ns/1ps

// ************************************************************
// Self-checking bench for the write enable controller
// ************************************************************
module test_spi_fram_write_enable_ctrl;
    // Expected strobe
    typedef struct packed {
        logic       wr;
        logic [8:0] addr;
        logic [7:0] data;
    } strobe_s;

    logic       i_clock;     // System clock
    logic       i_rst_n;     // Reset, active low
    logic       i_sck;       // Link clock
    logic       i_cs_n;      // Frame select
    logic       i_mosi;      // Link data
    logic [7:0] o_status;    // Status image
    logic       o_mem_wr;    // Write strobe
    logic       o_mem_rd;    // Read strobe
    logic [8:0] o_mem_addr;  // Strobe address
    logic [7:0] o_mem_wdata; // Write data
    int         n_mismatch;  // Failed compares
    int         cmp_count;   // All compares
    int         cycles;      // Watchdog
    int         seed;        // Random seed
    int         i;           // Loop index
    strobe_s    exp_q[$];    // Pending strobes
    logic [7:0] lo;          // Address byte
    logic [7:0] d1;          // Data byte
    logic [7:0] d2;          // Data byte
    logic [8:0] a;           // Read address

    // Host and device
    spi_host_model i_host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_mosi(i_mosi));
    fram_wel_ctrl i_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sck(i_sck),
        .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_status(o_status),
        .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata)
    );

    // 40 MHz system clock
    initial i_clock = 1'b0;
    always #12.5 i_clock = ~i_clock;

    // ************************************************************
    // Checking tasks
    // ************************************************************
    task automatic fail(input string msg);
        $display("mismatch at %0t: %s", $time, msg);
        n_mismatch++;
    endtask : fail

    // Let the frame settle, then compare status
    task automatic chk_status(input logic [7:0] e);
        repeat (8) @(negedge i_clock);
        cmp_count++;
        if (o_status !== e) fail("status value");
    endtask : chk_status

    // Note an expected strobe
    task automatic exp_strobe(input logic w, input logic [8:0] ad,
                              input logic [7:0] d);
        exp_q.push_back({w, ad, d});
    endtask : exp_strobe

    // Oldest note against the strobe just seen
    task automatic chk_strobe();
        strobe_s e;
        cmp_count++;
        if (exp_q.size() == 0) begin
            fail("unexpected strobe");
        end else begin
            e = exp_q.pop_front();
            if (o_mem_wr !== e.wr || o_mem_rd !== ~e.wr ||
                o_mem_addr !== e.addr ||
                (e.wr && o_mem_wdata !== e.data)) fail("strobe content");
        end
    endtask : chk_strobe

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Strobe watcher
    always @(negedge i_clock) begin
        if (o_mem_wr === 1'b1 || o_mem_rd === 1'b1) begin
            chk_strobe();
        end
    end

    // Watchdog
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        seed = 49;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        // Start high so the serial side's async clear sees an edge
        i_rst_n = 1'b1;
        @(negedge i_clock);
        i_rst_n = 1'b0;
        repeat (12) @(negedge i_clock);
        i_rst_n = 1'b1;
        chk_status(8'h00);
        lo = $random(seed);
        d1 = $random(seed);
        d2 = $random(seed);
        // Writes refused while disabled
        i_host.send_frame({fram_wel_pkg::OP_WR_LO, lo, d1, 8'h00}, 3);
        i_host.send_frame({fram_wel_pkg::OP_STAT_WR, 24'hFF0000}, 2);
        chk_status(8'h00);
        // Enable, then lower write clears the latch
        i_host.send_frame({fram_wel_pkg::OP_SET_WE, 24'h0}, 1);
        chk_status(8'h02);
        exp_strobe(1'b1, {1'b0, lo}, d1);
        i_host.send_frame({fram_wel_pkg::OP_WR_LO, lo, d1, 8'h00}, 3);
        chk_status(8'h00);
        // Upper write of two bytes leaves latch set
        i_host.send_frame({fram_wel_pkg::OP_SET_WE, 24'h0}, 1);
        exp_strobe(1'b1, {1'b1, lo}, d1);
        exp_strobe(1'b1, {1'b1, lo} + 9'h001, d2);
        i_host.send_frame({fram_wel_pkg::OP_WR_HI, lo, d1, d2}, 4);
        chk_status(8'h02);
        // Follow-on write needs no new enable
        exp_strobe(1'b1, {1'b0, lo}, d2);
        i_host.send_frame({fram_wel_pkg::OP_WR_LO, lo, d2, 8'h00}, 3);
        chk_status(8'h00);
        // Upper write, then the host's clear command
        i_host.send_frame({fram_wel_pkg::OP_SET_WE, 24'h0}, 1);
        exp_strobe(1'b1, {1'b1, lo}, d2);
        i_host.send_frame({fram_wel_pkg::OP_WR_HI, lo, d2, 8'h00}, 3);
        i_host.send_frame({fram_wel_pkg::OP_CLR_WE, 24'h0}, 1);
        chk_status(8'h00);
        // Status writes with a value and its inverse
        for (i = 0; i < 2; i++) begin
            d1 = ~d1;
            i_host.send_frame({fram_wel_pkg::OP_SET_WE, 24'h0}, 1);
            i_host.send_frame({fram_wel_pkg::OP_STAT_WR, d1, 16'h0}, 2);
            chk_status({4'h0, d1[3:2], 2'b00});
        end
        // Refused status write keeps protect bits
        i_host.send_frame({fram_wel_pkg::OP_STAT_WR, ~d1, 16'h0}, 2);
        chk_status({4'h0, d1[3:2], 2'b00});
        // Reads in both halves, one extra byte each
        for (i = 0; i < 2; i++) begin
            a = {i[0], lo};
            exp_strobe(1'b0, a, 8'h00);
            exp_strobe(1'b0, a + 9'h001, 8'h00);
            i_host.send_frame({i[0] ? fram_wel_pkg::OP_RD_HI
                : fram_wel_pkg::OP_RD_LO, lo, d2, 8'h00}, 3);
        end
        chk_status({4'h0, d1[3:2], 2'b00});
        cmp_count++;
        if (exp_q.size() != 0) fail("strobe missing");
        tally_and_finish();
    end
endmodule : test_spi_fram_write_enable_ctrl
